// [inc/fmu_regs.svh]
`ifndef FMU_REGS_SVH
`define FMU_REGS_SVH
`define FMU_VEC_W 256
`define FMU_HALF_W 128
`define FMU_IMM_W 8
`define FMU_SP_W 32
`define FMU_DP_W 64
`define FMU_SP_E 8
`define FMU_SP_F 23
`define FMU_DP_E 11
`define FMU_DP_F 52
`define FMU_SP_LANES 8
`define FMU_DP_LANES 4
`define FMU_IMM_RC_LO 0
`define FMU_IMM_RC_HI 1
`define FMU_IMM_RC_SEL 2
`define FMU_IMM_SUPP 3
`define FMU_FORM_NEG_ADD 0
`define FMU_FORM_NEG_PROD 1
`define FMU_FLG_W 5
`define FMU_FLG_INV 0
`define FMU_FLG_DEN 1
`define FMU_FLG_OVF 2
`define FMU_FLG_UNF 3
`define FMU_FLG_INX 4
`define FMU_FLG_RST 5'h00
`define FMU_SP_INF 31'h7F800000
`define FMU_SP_DNAN 32'hFFC00000
`define FMU_SP_QBIT 32'h00400000
`define FMU_SP_NZERO 32'h80000000
`endif

// [inc/fmu_pkg.sv]
`include "fmu_regs.svh"
package fmu_pkg;
  typedef enum logic [1:0] {
    fmu_rne,
    fmu_rdn,
    fmu_rup,
    fmu_rtz
  } fmu_round_e;
  typedef enum logic [1:0] {
    fmu_ord_132,
    fmu_ord_213,
    fmu_ord_231
  } fmu_order_e;
  typedef logic [`FMU_FLG_W-1:0] fmu_flags_t;
endpackage : fmu_pkg

// [design/fmu_core.sv]
// Summary of operation
// (RULE_01) Three sources, order select, result replaces first
// (RULE_02) Four signed forms of x*y and z
// (RULE_03) Eight single or four double lanes
// (RULE_04) Scalar: low element, keep low half, zero top
// (RULE_05) Exact product and sum, single rounding
// (RULE_06) Immediate bit 2 picks immediate rounding mode
// (RULE_07) Immediate bit 3 suppresses flags and traps
// (RULE_08) Immediate upper nibble ignored here
// (RULE_09) Quiet NaN passes, signaling NaN quieted
// (RULE_10) NaN priority x, y, z; SNaN signals invalid
// (RULE_11) NaN addend alone: quieted, invalid if signaling
// (RULE_12) Default NaN: sign one, top fraction one
// (RULE_13) Invalid operation gives default NaN, invalid flag
// (RULE_14) Infinite product plus infinity: agree or NaN
// (RULE_15) Infinite product, finite addend: signed infinity
// (RULE_16) Equal-sign zeros keep their sign
// (RULE_17) Opposite zeros or cancellation: minus only rounding down
// (RULE_18) Unmasked exception: destination kept, trap raised
// (RULE_19) Rounding codes: nearest, down, up, toward zero
// (RULE_20) Report denormal, overflow, underflow, inexact sticky
`timescale 1ns/1ns
`include "fmu_regs.svh"

module fmu_lane #(
  parameter int E = `FMU_SP_E,
  parameter int F = `FMU_SP_F
) (
  // Operands
  input wire logic [E+F:0] x_in,
  input wire logic [E+F:0] y_in,
  input wire logic [E+F:0] z_in,
  // Control
  input wire logic neg_prod_in,
  input wire logic neg_add_in,
  input wire fmu_pkg::fmu_round_e rm_in,
  // Result
  output logic [E+F:0] res_out,
  output fmu_pkg::fmu_flags_t flags_out
);
  import fmu_pkg::*;
  localparam int W = E + F + 1;
  // Guard span wide enough that cancellation never eats a lost bit
  localparam int G = 2 * F + 3;
  localparam int SW = 2 * F + 3 + G;
  localparam int NPOS = 2 * F + G + 1;
  localparam int BIAS = (1 << (E - 1)) - 1;
  localparam int EMAX = (1 << E) - 1;
  localparam logic [W-1:0] DNAN = {1'b1, {E{1'b1}}, 1'b1, {(F-1){1'b0}}};
  localparam logic [W-1:0] QBIT = {{(E+1){1'b0}}, 1'b1, {(F-1){1'b0}}};

  ////////////////////////////////////////////////////////////////////
  wire logic [W-1:0] opv [3];
  logic [2:0] is_nan;
  logic [2:0] is_snan;
  logic [2:0] is_inf;
  logic [2:0] is_zero;
  logic [2:0] is_den;
  logic [2:0] sgn;
  logic [F:0] man [3];
  logic signed [15:0] expo [3];

  assign opv[0] = x_in;
  assign opv[1] = y_in;
  assign opv[2] = z_in;

  for (genvar i = 0; i < 3; i++) begin : g_cls
    wire logic [E-1:0] ef = opv[i][W-2:F];
    wire logic [F-1:0] ff = opv[i][F-1:0];
    assign is_nan[i] = (&ef) && (|ff);
    assign is_snan[i] = is_nan[i] && !ff[F-1];
    assign is_inf[i] = (&ef) && !(|ff);
    assign is_zero[i] = !(|ef) && !(|ff);
    assign is_den[i] = !(|ef) && (|ff);
    assign sgn[i] = opv[i][W-1];
    assign man[i] = {|ef, ff};
    assign expo[i] = (|ef) ? 16'(ef) : 16'sh0001;
  end

  ////////////////////////////////////////////////////////////////////
  wire logic ps = sgn[0] ^ sgn[1] ^ neg_prod_in; // [RULE_02]
  wire logic zs = sgn[2] ^ neg_add_in; // [RULE_02]
  wire logic eff_sub = ps ^ zs;

  wire logic [2*F+1:0] prod = man[0] * man[1]; // [RULE_05]
  wire logic signed [15:0] ep = expo[0] + expo[1] - 16'(BIAS);
  wire logic signed [15:0] ez = expo[2];
  wire logic p_big = ep >= ez;
  wire logic signed [15:0] eb = p_big ? ep : ez;
  wire logic [15:0] dp = 16'(eb - ep);
  wire logic [15:0] dz = 16'(eb - ez);
  wire logic [SW-1:0] pf = {prod, {(G+1){1'b0}}};
  wire logic [SW-1:0] zf = {1'b0, man[2], {(F+G+1){1'b0}}};
  wire logic [SW-1:0] pa = pf >> dp;
  wire logic [SW-1:0] za = zf >> dz;
  // Shifted-out bits are jammed into the lsb, which sits below round
  wire logic [SW-1:0] pj = {pa[SW-1:1], pa[0] | ((pa << dp) != pf)}; // [RULE_05]
  wire logic [SW-1:0] zj = {za[SW-1:1], za[0] | ((za << dz) != zf)}; // [RULE_05]
  wire logic p_ge = pj >= zj;
  wire logic [SW:0] mag = !eff_sub ? {1'b0, pj} + {1'b0, zj} :
                          p_ge ? {1'b0, pj - zj} : {1'b0, zj - pj};
  wire logic msign = (eff_sub && !p_ge) ? zs : ps;

  logic signed [15:0] lead;
  always_comb begin
    lead = '0;
    for (int i = 0; i <= SW; i++) begin
      if (mag[i]) begin
        lead = 16'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  wire logic signed [15:0] er = eb + lead - 16'(NPOS);
  wire logic tiny = er < 16'sh0001;
  wire logic signed [15:0] lsb = lead - 16'(F) +
                                 (tiny ? 16'sh0001 - er : 16'sh0000);
  wire logic lpos = lsb > 16'sh0000;
  wire logic [15:0] sh = lpos ? 16'(lsb) : 16'(-lsb);
  wire logic [SW:0] kept = lpos ? mag >> sh : mag << sh;
  wire logic [SW:0] hsh = mag >> (sh - 16'h0001);
  wire logic rnd = lpos && hsh[0];
  wire logic stk = lpos && ((hsh << (sh - 16'h0001)) != mag);
  wire logic inx_r = rnd | stk;
  wire logic inc = (rm_in == fmu_rne) ? rnd & (stk | kept[0]) :
                   (rm_in == fmu_rdn) ? inx_r & msign :
                   (rm_in == fmu_rup) ? inx_r & !msign : 1'b0; // [RULE_19]
  wire logic [E-1:0] efld = tiny ? '0 : er[E-1:0];
  // Carry from the fraction walks into the exponent field on its own
  wire logic [W-1:0] pk = {1'b0, efld, kept[F-1:0]} + W'(inc); // [RULE_05]
  wire logic ovf = (er >= 16'(EMAX)) || (&pk[W-2:F]);
  wire logic to_max = (rm_in == fmu_rtz) ||
                      (rm_in == fmu_rdn && !msign) ||
                      (rm_in == fmu_rup && msign);
  wire logic [W-2:0] maxf = {{(E-1){1'b1}}, 1'b0, {F{1'b1}}};
  wire logic [W-2:0] inf_m = {{E{1'b1}}, {F{1'b0}}};
  wire logic [W-1:0] fin = ovf ? {msign, to_max ? maxf : inf_m} :
                           {msign, pk[W-2:0]};
  wire logic zsign = eff_sub ? (rm_in == fmu_rdn) : ps; // [RULE_16] [RULE_17]

  ////////////////////////////////////////////////////////////////////
  wire logic p_inf = is_inf[0] | is_inf[1];
  wire logic p_zero = is_zero[0] | is_zero[1];
  wire logic any_nan = |is_nan;
  wire logic bad_mul = p_inf && p_zero; // [RULE_13]
  wire logic bad_add = p_inf && is_inf[2] && eff_sub; // [RULE_14]
  wire logic special = any_nan || p_inf || is_inf[2];

  assign res_out =
    is_nan[0] ? opv[0] | QBIT : // [RULE_09] [RULE_10]
    is_nan[1] ? opv[1] | QBIT : // [RULE_10]
    is_nan[2] ? opv[2] | QBIT : // [RULE_11]
    (bad_mul || bad_add) ? DNAN : // [RULE_12] [RULE_13] [RULE_14]
    p_inf ? {ps, inf_m} : // [RULE_14] [RULE_15]
    is_inf[2] ? {zs, inf_m} :
    (mag == '0) ? {zsign, {(W-1){1'b0}}} : fin; // [RULE_16] [RULE_17]

  // Once any NaN is present the snan test covers all three inputs
  assign flags_out[`FMU_FLG_INV] = any_nan ? |is_snan :
                                   bad_mul | bad_add; // [RULE_10] [RULE_11]
  assign flags_out[`FMU_FLG_DEN] = !any_nan && (|is_den); // [RULE_20]
  assign flags_out[`FMU_FLG_OVF] = !special && mag != '0 && ovf; // [RULE_20]
  assign flags_out[`FMU_FLG_UNF] = !special && mag != '0 &&
                                   !(|pk[W-2:F]) && inx_r; // [RULE_20]
  assign flags_out[`FMU_FLG_INX] = !special && mag != '0 &&
                                   (inx_r || ovf); // [RULE_20]
endmodule : fmu_lane

module fmu_core (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Issue
  input wire logic valid_in,
  input wire fmu_pkg::fmu_order_e order_in,
  input wire logic [1:0] form_in,
  input wire logic double_in,
  input wire logic scalar_in,
  input wire logic [`FMU_IMM_W-1:0] immediate_control_byte_in,
  input wire logic [`FMU_VEC_W-1:0] src1_in,
  input wire logic [`FMU_VEC_W-1:0] src2_in,
  input wire logic [`FMU_VEC_W-1:0] src3_in,
  // Control and status
  input wire fmu_pkg::fmu_round_e simd_fp_control_status_rc_in,
  input wire fmu_pkg::fmu_flags_t simd_fp_control_status_mask_in,
  input wire logic flag_clear_in,
  output fmu_pkg::fmu_flags_t simd_fp_control_status_flags_out,
  output logic invalid_operation_flag_out,
  // Result
  output logic valid_out,
  output logic [`FMU_VEC_W-1:0] result_out,
  output logic fault_out
);
  import fmu_pkg::*;

  ////////////////////////////////////////////////////////////////////
  wire logic [`FMU_VEC_W-1:0] opx = (order_in == fmu_ord_132) ?
                                    src1_in : src2_in; // [RULE_01]
  wire logic [`FMU_VEC_W-1:0] opy = (order_in == fmu_ord_213) ?
                                    src1_in : src3_in; // [RULE_01]
  wire logic [`FMU_VEC_W-1:0] opz = (order_in == fmu_ord_132) ? src2_in :
                                    (order_in == fmu_ord_213) ? src3_in :
                                    src1_in; // [RULE_01]
  // Only the low nibble of the immediate steers arithmetic
  wire logic [`FMU_IMM_RC_HI:0] imm_rc =
    immediate_control_byte_in[`FMU_IMM_RC_HI:`FMU_IMM_RC_LO]; // [RULE_08]
  wire fmu_round_e rm = immediate_control_byte_in[`FMU_IMM_RC_SEL] ?
                        fmu_round_e'(imm_rc) :
                        simd_fp_control_status_rc_in; // [RULE_06] [RULE_19]
  wire logic supp = immediate_control_byte_in[`FMU_IMM_SUPP]; // [RULE_07]
  wire logic neg_add = form_in[`FMU_FORM_NEG_ADD];
  wire logic neg_prod = form_in[`FMU_FORM_NEG_PROD];

  ////////////////////////////////////////////////////////////////////
  wire logic [`FMU_VEC_W-1:0] sp_res;
  wire logic [`FMU_VEC_W-1:0] dp_res;
  fmu_flags_t sp_flg [`FMU_SP_LANES];
  fmu_flags_t dp_flg [`FMU_DP_LANES];

  for (genvar i = 0; i < `FMU_SP_LANES; i++) begin : g_sp // [RULE_03]
    fmu_lane #(.E(`FMU_SP_E), .F(`FMU_SP_F)) fmu_lane_i (
      .x_in(opx[i*`FMU_SP_W +: `FMU_SP_W]),
      .y_in(opy[i*`FMU_SP_W +: `FMU_SP_W]),
      .z_in(opz[i*`FMU_SP_W +: `FMU_SP_W]),
      .neg_prod_in(neg_prod),
      .neg_add_in(neg_add),
      .rm_in(rm),
      .res_out(sp_res[i*`FMU_SP_W +: `FMU_SP_W]),
      .flags_out(sp_flg[i])
    );
  end

  for (genvar i = 0; i < `FMU_DP_LANES; i++) begin : g_dp // [RULE_03]
    fmu_lane #(.E(`FMU_DP_E), .F(`FMU_DP_F)) fmu_lane_i (
      .x_in(opx[i*`FMU_DP_W +: `FMU_DP_W]),
      .y_in(opy[i*`FMU_DP_W +: `FMU_DP_W]),
      .z_in(opz[i*`FMU_DP_W +: `FMU_DP_W]),
      .neg_prod_in(neg_prod),
      .neg_add_in(neg_add),
      .rm_in(rm),
      .res_out(dp_res[i*`FMU_DP_W +: `FMU_DP_W]),
      .flags_out(dp_flg[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  wire logic [`FMU_HALF_W-1:0] top_zero = '0;
  wire logic [`FMU_VEC_W-1:0] packed_res = double_in ? dp_res : sp_res;
  wire logic [`FMU_VEC_W-1:0] scalar_res = double_in ?
    {top_zero, src1_in[`FMU_HALF_W-1:`FMU_DP_W], dp_res[`FMU_DP_W-1:0]} :
    {top_zero, src1_in[`FMU_HALF_W-1:`FMU_SP_W],
     sp_res[`FMU_SP_W-1:0]}; // [RULE_04]

  fmu_flags_t lane_flg;
  always_comb begin
    lane_flg = '0;
    for (int i = 0; i < `FMU_SP_LANES; i++) begin
      if (!double_in && (!scalar_in || i == 0)) begin
        lane_flg = lane_flg | sp_flg[i]; // [RULE_04]
      end
    end
    for (int i = 0; i < `FMU_DP_LANES; i++) begin
      if (double_in && (!scalar_in || i == 0)) begin
        lane_flg = lane_flg | dp_flg[i]; // [RULE_04]
      end
    end
  end

  // Suppressed results already are the masked ones, so only gate flags
  wire fmu_flags_t raised = (valid_in && !supp) ? lane_flg : '0; // [RULE_07]
  wire logic trap = |(raised & ~simd_fp_control_status_mask_in); // [RULE_18]
  wire logic [`FMU_VEC_W-1:0] result_next = trap ? src1_in :
    scalar_in ? scalar_res : packed_res; // [RULE_18] [RULE_01]
  // A new event in the clearing cycle still lands in the flags
  wire fmu_flags_t flags_next =
    (flag_clear_in ? `FMU_FLG_RST : simd_fp_control_status_flags_out)
    | raised; // [RULE_20]

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      valid_out <= 1'b0;
      fault_out <= 1'b0;
      result_out <= '0;
      simd_fp_control_status_flags_out <= `FMU_FLG_RST;
      invalid_operation_flag_out <= 1'b0;
    end else begin
      valid_out <= valid_in;
      fault_out <= trap;
      if (valid_in) begin
        result_out <= result_next;
      end
      simd_fp_control_status_flags_out <= flags_next;
      invalid_operation_flag_out <= flags_next[`FMU_FLG_INV]; // [RULE_13]
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  wire logic [`FMU_SP_W-1:0] ax = opx[`FMU_SP_W-1:0];
  wire logic [`FMU_SP_W-1:0] ay = opy[`FMU_SP_W-1:0];
  wire logic [`FMU_SP_W-1:0] az = opz[`FMU_SP_W-1:0];
  wire logic ax_inf = ax[`FMU_SP_W-2:0] == `FMU_SP_INF;
  wire logic ax_zero = ax[`FMU_SP_W-2:0] == '0;
  wire logic ay_zero = ay[`FMU_SP_W-2:0] == '0;
  wire logic az_zero = az[`FMU_SP_W-2:0] == '0;
  wire logic az_nan = az[`FMU_SP_W-2:0] > `FMU_SP_INF;
  wire logic ax_snan = ax[`FMU_SP_W-2:0] > `FMU_SP_INF &&
                       !ax[`FMU_SP_F-1];
  wire logic sp_scalar = valid_in && scalar_in && !double_in;
  wire logic zero_opp = (ax[`FMU_SP_W-1] ^ ay[`FMU_SP_W-1] ^ neg_prod)
                        != (az[`FMU_SP_W-1] ^ neg_add);
  wire logic [`FMU_HALF_W-1:`FMU_SP_W] keep_lo =
    src1_in[`FMU_HALF_W-1:`FMU_SP_W];

  a_issue_latency: assert property ( // [RULE_01]
    ##1 valid_out == $past(valid_in))
    else $error("result valid not one cycle after issue");
  a_scalar_upper_zero: assert property ( // [RULE_04]
    valid_in && scalar_in |=>
    fault_out || result_out[`FMU_VEC_W-1:`FMU_HALF_W] == '0)
    else $error("scalar result upper half not zero");
  a_scalar_keep_low: assert property ( // [RULE_04]
    sp_scalar |=> fault_out ||
    result_out[`FMU_HALF_W-1:`FMU_SP_W] == $past(keep_lo))
    else $error("scalar result lost destination elements");
  a_fault_keeps_dest: assert property ( // [RULE_18]
    fault_out |-> result_out == $past(src1_in))
    else $error("trapping result overwrote destination");
  a_suppress_quiet: assert property ( // [RULE_07]
    valid_in && supp && !flag_clear_in |=> !fault_out &&
    simd_fp_control_status_flags_out ==
    $past(simd_fp_control_status_flags_out))
    else $error("suppressed operation touched flags or trapped");
  a_flags_sticky: assert property ( // [RULE_20]
    !flag_clear_in |=> (simd_fp_control_status_flags_out &
    $past(simd_fp_control_status_flags_out)) ==
    $past(simd_fp_control_status_flags_out))
    else $error("sticky flag dropped without clear");
  a_default_nan: assert property ( // [RULE_13]
    sp_scalar && ax_inf && ay_zero && !az_nan &&
    (supp || (&simd_fp_control_status_mask_in)) |=>
    result_out[`FMU_SP_W-1:0] == `FMU_SP_DNAN)
    else $error("infinity times zero did not give default NaN");
  a_snan_quiet: assert property ( // [RULE_09]
    sp_scalar && supp && ax_snan |=>
    result_out[`FMU_SP_W-1:0] == ($past(ax) | `FMU_SP_QBIT))
    else $error("signaling NaN not quieted");
  a_zero_round_down: assert property ( // [RULE_17]
    sp_scalar && supp && ax_zero && ay_zero && az_zero && zero_opp &&
    rm == fmu_rdn |=> result_out[`FMU_SP_W-1:0] == `FMU_SP_NZERO)
    else $error("opposite zeros under round down not negative");
  a_snan_invalid: assert property ( // [RULE_10]
    sp_scalar && !supp && ax_snan |=> invalid_operation_flag_out)
    else $error("signaling NaN did not raise invalid");

  c_packed_double: cover property (valid_in && double_in && !scalar_in);
  c_scalar_single: cover property (sp_scalar);
  c_trap: cover property (fault_out);
  c_suppressed: cover property (valid_in && supp);
endmodule : fmu_core

// [sim/fmu_issue_model.sv]
`timescale 1ns/1ns
`include "fmu_regs.svh"

module fmu_issue_model (
  // Clock
  input wire logic clock_in,
  // Issue
  output logic valid_out,
  output fmu_pkg::fmu_order_e order_out,
  output logic [1:0] form_out,
  output logic double_out,
  output logic scalar_out,
  output logic [`FMU_IMM_W-1:0] imm_out,
  output logic [`FMU_VEC_W-1:0] src1_out,
  output logic [`FMU_VEC_W-1:0] src2_out,
  output logic [`FMU_VEC_W-1:0] src3_out,
  // Control and status
  output fmu_pkg::fmu_round_e rc_out,
  output fmu_pkg::fmu_flags_t mask_out,
  output logic clear_out
);
  import fmu_pkg::*;

  initial begin
    valid_out = 1'b0;
    order_out = fmu_ord_132;
    form_out = 2'h0;
    double_out = 1'b0;
    scalar_out = 1'b0;
    imm_out = 8'h00;
    src1_out = '0;
    src2_out = '0;
    src3_out = '0;
    rc_out = fmu_rne;
    mask_out = 5'h1F;
    clear_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One issue slot; returns just after the answering edge
  task automatic issue(input fmu_order_e ord, input logic [1:0] frm,
    input logic dbl, input logic scl, input logic [7:0] imm,
    input logic [255:0] a, input logic [255:0] b, input logic [255:0] c,
    input fmu_round_e rc, input fmu_flags_t msk);
    @(posedge clock_in);
    #1;
    valid_out = 1'b1;
    order_out = ord;
    form_out = frm;
    double_out = dbl;
    scalar_out = scl;
    imm_out = imm;
    src1_out = a;
    src2_out = b;
    src3_out = c;
    rc_out = rc;
    mask_out = msk;
    @(posedge clock_in);
    #1;
    valid_out = 1'b0;
    // Stale operands are inverted so a late sample cannot pass by luck
    src1_out = ~a;
    src2_out = ~b;
    src3_out = ~c;
  endtask : issue

  task automatic clear_flags();
    @(posedge clock_in);
    #1;
    clear_out = 1'b1;
    @(posedge clock_in);
    #1;
    clear_out = 1'b0;
  endtask : clear_flags
endmodule : fmu_issue_model

// [sim/fused_multiply_add_unit_tb.sv]
`timescale 1ns/1ns
`include "fmu_regs.svh"

module fused_multiply_add_unit_tb;
  import fmu_pkg::*;

  logic clock_in;
  logic rstn_in;
  logic valid_in;
  fmu_order_e order_in;
  logic [1:0] form_in;
  logic double_in;
  logic scalar_in;
  logic [7:0] imm_in;
  logic [255:0] src1_in;
  logic [255:0] src2_in;
  logic [255:0] src3_in;
  fmu_round_e rc_in;
  fmu_flags_t mask_in;
  logic clear_in;
  fmu_flags_t flags_out;
  logic inv_out;
  logic valid_out;
  logic [255:0] result_out;
  logic fault_out;
  int fails = 0;
  int tests_run = 0;
  fmu_flags_t msk = 5'h1F;
  logic [31:0] fexp [4] = '{32'h40E00000, 32'h40A00000, 32'hC0A00000,
    32'hC0E00000};
  logic [31:0] oexp [4] = '{32'h41300000, 32'h41200000, 32'h41600000,
    32'h41600000};
  // Specials: x, y, z, result; then invalid, rounding, form
  logic [31:0] tv [15][4] = '{
    '{32'h7F800001, 32'h7FC00002, 32'h7FC00003, 32'h7FC00001},
    '{32'h3F800000, 32'hFFC00003, 32'h7F800004, 32'hFFC00003},
    '{32'h3F800000, 32'h3F800000, 32'h7FC00007, 32'h7FC00007},
    '{32'h3F800000, 32'h3F800000, 32'hFF800009, 32'hFFC00009},
    '{32'h7F800000, 32'h00000000, 32'h3F800000, 32'hFFC00000},
    '{32'h7F800000, 32'h3F800000, 32'hFF800000, 32'hFFC00000},
    '{32'h7F800000, 32'h3F800000, 32'hFF800000, 32'h7F800000},
    '{32'h7F800000, 32'hBF800000, 32'h3F800000, 32'hFF800000},
    '{32'h7F800000, 32'hBF800000, 32'h3F800000, 32'h7F800000},
    '{32'h00000000, 32'h3F800000, 32'h00000000, 32'h00000000},
    '{32'h80000000, 32'h3F800000, 32'h00000000, 32'h80000000},
    '{32'h00000000, 32'h00000000, 32'h00000000, 32'h80000000},
    '{32'h00000000, 32'h3F800000, 32'h00000000, 32'h00000000},
    '{32'h40000000, 32'h40400000, 32'h40C00000, 32'h80000000},
    '{32'h40000000, 32'h40400000, 32'h40C00000, 32'h00000000}};
  logic [4:0] tc [15] = '{5'h10, 5'h11, 5'h03, 5'h10, 5'h10, 5'h10, 5'h01,
    5'h00, 5'h02, 5'h04, 5'h05, 5'h05, 5'h01, 5'h05, 5'h09};

  fmu_core fmu_core_i (
    .clock_in(clock_in), .rstn_in(rstn_in), .valid_in(valid_in),
    .order_in(order_in), .form_in(form_in), .double_in(double_in),
    .scalar_in(scalar_in), .immediate_control_byte_in(imm_in),
    .src1_in(src1_in), .src2_in(src2_in), .src3_in(src3_in),
    .simd_fp_control_status_rc_in(rc_in),
    .simd_fp_control_status_mask_in(mask_in), .flag_clear_in(clear_in),
    .simd_fp_control_status_flags_out(flags_out),
    .invalid_operation_flag_out(inv_out), .valid_out(valid_out),
    .result_out(result_out), .fault_out(fault_out));

  fmu_issue_model fmu_issue_model_i (
    .clock_in(clock_in), .valid_out(valid_in), .order_out(order_in),
    .form_out(form_in), .double_out(double_in), .scalar_out(scalar_in),
    .imm_out(imm_in), .src1_out(src1_in), .src2_out(src2_in),
    .src3_out(src3_in), .rc_out(rc_in), .mask_out(mask_in),
    .clear_out(clear_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Packed single, order 213 so x=src2, y=src1, z=src3
  task automatic sp(input logic [1:0] frm, input logic [7:0] imm,
    input fmu_round_e rc, input logic [31:0] x, input logic [31:0] y,
    input logic [31:0] z, input logic [31:0] ex);
    fmu_issue_model_i.issue(fmu_ord_213, frm, 1'b0, 1'b0, imm, {8{y}},
      {8{x}}, {8{z}}, rc, msk);
    chk(256'(valid_out), 256'h1);
    chk(result_out, {8{ex}});
  endtask : sp

  task automatic flg(input logic [4:0] ex);
    chk(256'(flags_out), 256'(ex));
    chk(256'(inv_out), 256'(ex[`FMU_FLG_INV]));
  endtask : flg

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    fails++;
    $display("[ERR] %0t ns: run did not finish", $time);
    stop_test();
  end

  initial begin
    rstn_in = 1'b0;
    repeat (16) @(posedge clock_in);
    #1;
    rstn_in = 1'b1;
    for (int f = 0; f < 4; f++) begin
      sp(f[1:0], 8'h00, fmu_rne, 32'h40000000, 32'h40400000,
        32'h3F800000, fexp[f]);
    end
    @(posedge clock_in);
    #1;
    chk(result_out, {8{fexp[3]}});
    for (int o = 0; o < 4; o++) begin
      fmu_issue_model_i.issue(fmu_order_e'(o), 2'b00, 1'b0, 1'b0, 8'h00,
        {8{32'h40000000}}, {8{32'h40400000}}, {8{32'h40800000}}, fmu_rne,
        msk);
      chk(result_out, {8{oexp[o]}});
    end
    fmu_issue_model_i.issue(fmu_ord_213, 2'b00, 1'b1, 1'b0, 8'h00,
      {4{64'h4000000000000000}}, {4{64'h4008000000000000}},
      {4{64'h3FF0000000000000}}, fmu_rne, msk);
    chk(result_out, {4{64'h401C000000000000}});
    fmu_issue_model_i.issue(fmu_ord_213, 2'b00, 1'b1, 1'b1, 8'h00,
      {64'hAAAAAAAAAAAAAAAA, 64'h5555555555555555, 64'h1234567812345678,
      64'h4000000000000000}, {4{64'h4008000000000000}},
      {4{64'h3FF0000000000000}}, fmu_rne, msk);
    chk(result_out, {128'h0, 64'h1234567812345678,
      64'h401C000000000000});
    // Halfway product: the sign pair tells all four modes apart
    for (int m = 0; m < 4; m++) begin
      sp(2'b00, {4'hF, 2'b01, m[1:0]}, fmu_round_e'(~m[1:0]),
        32'h3F800001, 32'h3FC00000, 32'h0,
        {24'h3FC000, (m[0] ? 8'h01 : 8'h02)});
      sp(2'b10, {4'hF, 2'b00, ~m[1:0]}, fmu_round_e'(m[1:0]),
        32'h3F800001, 32'h3FC00000, 32'h0,
        {24'hBFC000, (m[1] ? 8'h01 : 8'h02)});
    end
    fmu_issue_model_i.clear_flags();
    sp(2'b00, 8'h08, fmu_rne, 32'h3F800001, 32'h3FC00000, 32'h0,
      32'h3FC00002);
    flg(5'h00);
    sp(2'b00, 8'h00, fmu_rne, 32'h3F800001, 32'h3FC00000, 32'h0,
      32'h3FC00002);
    flg(5'h10);
    msk = 5'h0F;
    sp(2'b00, 8'h00, fmu_rne, 32'h3F800001, 32'h3FC00000, 32'h0,
      32'h3FC00000);
    chk(256'(fault_out), 256'h1);
    sp(2'b00, 8'h08, fmu_rne, 32'h3F800001, 32'h3FC00000, 32'h0,
      32'h3FC00002);
    chk(256'(fault_out), 256'h0);
    msk = 5'h1F;
    for (int i = 0; i < 15; i++) begin
      fmu_issue_model_i.clear_flags();
      sp(tc[i][1:0], 8'h00, fmu_round_e'(tc[i][3:2]), tv[i][0], tv[i][1],
        tv[i][2], tv[i][3]);
      flg({4'h0, tc[i][4]});
      // Scalar single, plain then suppressed, reaches the lane-0 checks
      for (int s = 0; s < 2; s++) begin
        fmu_issue_model_i.issue(fmu_ord_213, tc[i][1:0], 1'b0, 1'b1,
          {4'h0, s[0], 3'h0}, {8{tv[i][1]}}, {8{tv[i][0]}}, {8{tv[i][2]}},
          fmu_round_e'(tc[i][3:2]), msk);
        chk(result_out, {128'h0, {3{tv[i][1]}}, tv[i][3]});
      end
    end
    stop_test();
  end
endmodule : fused_multiply_add_unit_tb
